// [core/ccl_interp.sv]
`timescale 1ns/10ps
`default_nettype none
// y = a.y +/- (x - a.x) * |b.y - a.y| / (b.x - a.x), one bit per cycle
module ccl_interp (
  input  wire logic           i_clk,
  input  wire logic           i_sys_rst,
  input  wire logic           i_start,
  input  wire logic [15:0]    i_x,
  input  wire ccl_pkg::ccl_pt_s i_a,
  input  wire ccl_pkg::ccl_pt_s i_b,
  output logic                o_done,
  output logic [15:0]         o_y
);
  logic [31:0] num_reg;
  logic [31:0] quo_reg;
  logic [16:0] rem_reg;
  logic [15:0] dx_reg;
  logic [15:0] base_reg;
  logic        neg_reg;
  logic [5:0]  cnt_reg;
  logic        run_reg;
  logic [16:0] rem_next;
  logic [15:0] dy;

  assign dy = (i_b.y >= i_a.y) ? i_b.y - i_a.y : i_a.y - i_b.y;
  assign rem_next = {rem_reg[15:0], num_reg[31]};

  // restoring long division of the scaled offset by the segment width
  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_sys_rst) begin
      run_reg <= 1'b0;
      cnt_reg <= 6'h3F; // idle marker, no done pulse before a division
      num_reg <= '0;
      quo_reg <= '0;
      rem_reg <= '0;
      dx_reg <= '0;
      base_reg <= '0;
      neg_reg <= 1'b0;
      o_y <= '0;
    end else if (i_start) begin
      run_reg <= 1'b1;
      cnt_reg <= 6'(ccl_pkg::DIV_STEPS);
      num_reg <= (i_x - i_a.x) * dy;
      quo_reg <= '0;
      rem_reg <= '0;
      dx_reg <= i_b.x - i_a.x;
      base_reg <= i_a.y;
      neg_reg <= i_b.y < i_a.y;
    end else if (run_reg) begin
      num_reg <= {num_reg[30:0], 1'b0};
      if (rem_next >= {1'b0, dx_reg}) begin
        rem_reg <= rem_next - {1'b0, dx_reg};
        quo_reg <= {quo_reg[30:0], 1'b1};
      end else begin
        rem_reg <= rem_next;
        quo_reg <= {quo_reg[30:0], 1'b0};
      end
      cnt_reg <= cnt_reg - 6'h01;
      if (cnt_reg == 6'h01) begin
        run_reg <= 1'b0;
      end
    end else if (cnt_reg == 6'h00) begin
      cnt_reg <= 6'h3F;
    end
    if (!i_sys_rst && !i_start && !run_reg && cnt_reg == 6'h00) begin
      o_done <= 1'b1;
      o_y <= neg_reg ? base_reg - quo_reg[15:0] : base_reg + quo_reg[15:0];
    end
  end
endmodule
`default_nettype wire

// [core/ccl_interp_note.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [core/ccl_linearizer.sv]
`timescale 1ns/10ps
`default_nettype none
module ccl_linearizer (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_sample_valid,
  input  wire logic [15:0] i_sample_pct,
  input  wire logic        i_sample_class,
  input  wire logic        i_hour_tick,
  input  wire logic [15:0] i_etemp,
  input  wire logic [3:0]  i_limit_hit,
  input  wire logic [3:0]  i_err_cond,
  output logic             o_pv_valid,
  output logic [15:0]      o_pv_pct,
  output logic             o_alarm,
  output logic             o_warn,
  output logic [2:0]       o_diag_code
);
  typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_DIV, ST_CHECK} ccl_state_e;

  ccl_state_e        state_reg;
  ccl_pkg::ccl_cfg_s cfg_reg;
  ccl_pkg::ccl_pt_s  sp_reg [ccl_pkg::MAX_INNER];
  ccl_pkg::ccl_pt_s  ap_reg [ccl_pkg::MAX_INNER];
  ccl_pkg::ccl_pt_s  seg_a, seg_b, chk_a, chk_b;
  logic [31:0]       span_reg, offs_reg, trim_reg, ident_reg, aout_reg, alarm_reg, dcfg_reg;
  logic [31:0]       pvrt_reg, dvrt_reg, rd_mux;
  logic [15:0]       xin_reg, pv_hold_reg, pv_min_reg, pv_max_reg, et_min_reg, et_max_reg, div_y;
  logic [5:0]        scnt_reg, acnt_reg, idx_reg;
  logic [2:0]        diag_next;
  logic              curve_en_reg, commit_reg, reject_reg, up_ok_reg, dn_ok_reg, pv_seen_reg;
  logic              div_start_reg, res_valid_reg, rd_err, acc, wr, freset, pv_clr, div_done;
  logic              pv_fresh;

  // point k of a table, endpoints implied outside the stored entries
  function automatic ccl_pkg::ccl_pt_s pt(input logic stg, input logic [5:0] k);
    logic [5:0] n;
    n = stg ? scnt_reg : acnt_reg;
    if (k == 6'h00) begin
      pt = '0;
    end else if (k > n) begin
      pt = {ccl_pkg::PCT_FULL, ccl_pkg::PCT_FULL};
    end else begin
      pt = stg ? sp_reg[5'(k - 6'h01)] : ap_reg[5'(k - 6'h01)];
    end
  endfunction

  assign acc    = i_psel & i_penable & o_pready;
  assign wr     = acc & i_pwrite;
  assign freset = wr && i_paddr == ccl_pkg::OFS_CTRL && i_pwdata[ccl_pkg::CTRL_FRESET];
  assign pv_clr = wr && i_paddr == ccl_pkg::OFS_CTRL && i_pwdata[ccl_pkg::CTRL_PV_CLR];
  assign pv_fresh = !pv_seen_reg || freset || pv_clr; // next result opens a new window
  assign seg_a  = pt(1'b0, idx_reg);
  assign seg_b  = pt(1'b0, idx_reg + 6'h01);
  assign chk_a  = pt(1'b1, idx_reg);
  assign chk_b  = pt(1'b1, idx_reg + 6'h01);

  // apb answer one cycle into the access phase
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & rd_err;
      if (i_psel & i_penable & ~o_pready & ~i_pwrite) begin
        o_prdata <= rd_mux;
      end
    end
  end

  // read decode
  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    if (i_paddr >= ccl_pkg::OFS_TBL && i_paddr <= ccl_pkg::OFS_TEND && i_paddr[1:0] == 2'h0) begin
      rd_mux = sp_reg[5'((i_paddr - ccl_pkg::OFS_TBL) >> 2)];
    end else begin
      case (i_paddr)
        ccl_pkg::OFS_CTRL:  rd_mux = {31'h0, curve_en_reg};
        ccl_pkg::OFS_STAT:  rd_mux = {16'h0, 2'h0, acnt_reg, 3'h0, o_warn, o_alarm,
                                      state_reg != ST_IDLE, reject_reg, commit_reg};
        ccl_pkg::OFS_CFG:   rd_mux = cfg_reg;
        ccl_pkg::OFS_SPAN:  rd_mux = span_reg;
        ccl_pkg::OFS_OFFS:  rd_mux = offs_reg;
        ccl_pkg::OFS_TRIM:  rd_mux = trim_reg;
        ccl_pkg::OFS_IDENT: rd_mux = ident_reg;
        ccl_pkg::OFS_AOUT:  rd_mux = aout_reg;
        ccl_pkg::OFS_ALARM: rd_mux = alarm_reg;
        ccl_pkg::OFS_PVMM:  rd_mux = {pv_max_reg, pv_min_reg};
        ccl_pkg::OFS_ETMM:  rd_mux = {et_max_reg, et_min_reg};
        ccl_pkg::OFS_PVRT:  rd_mux = pvrt_reg;
        ccl_pkg::OFS_DVRT:  rd_mux = dvrt_reg;
        ccl_pkg::OFS_TCNT:  rd_mux = {26'h0, scnt_reg};
        ccl_pkg::OFS_DCFG:  rd_mux = dcfg_reg;
        ccl_pkg::OFS_DSTAT: rd_mux = {20'h0, i_err_cond, i_limit_hit, 1'b0, o_diag_code};
        default:            rd_err = 1'b1;
      endcase
    end
  end

  // configuration store and factory reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg_reg <= ccl_pkg::CFG_RST;
      span_reg <= ccl_pkg::SPAN_RST;
      offs_reg <= '0;
      trim_reg <= '0;
      ident_reg <= '0;
      aout_reg <= '0;
      alarm_reg <= '0;
      dcfg_reg <= ccl_pkg::DCFG_RST;
      curve_en_reg <= 1'b0;
      scnt_reg <= '0;
    end else if (freset) begin
      cfg_reg <= ccl_pkg::CFG_RST;
      span_reg <= ccl_pkg::SPAN_RST;
      offs_reg <= '0;
      trim_reg <= '0;
      curve_en_reg <= 1'b0;
    end else if (wr) begin
      case (i_paddr)
        ccl_pkg::OFS_CTRL:  curve_en_reg <= i_pwdata[ccl_pkg::CTRL_CURVE_EN];
        ccl_pkg::OFS_CFG:   cfg_reg <= i_pwdata;
        ccl_pkg::OFS_SPAN:  span_reg <= i_pwdata;
        ccl_pkg::OFS_OFFS:  offs_reg <= i_pwdata;
        ccl_pkg::OFS_TRIM:  trim_reg <= i_pwdata;
        ccl_pkg::OFS_IDENT: ident_reg <= i_pwdata;
        ccl_pkg::OFS_AOUT:  aout_reg <= i_pwdata;
        ccl_pkg::OFS_ALARM: alarm_reg <= i_pwdata;
        ccl_pkg::OFS_TCNT:  scnt_reg <= i_pwdata[5:0];
        ccl_pkg::OFS_DCFG:  dcfg_reg <= i_pwdata;
        default: begin
        end
      endcase
    end
  end

  // staged table entries, percent-of-span pairs
  always_ff @(posedge i_clk) begin
    if (wr && i_paddr >= ccl_pkg::OFS_TBL && i_paddr <= ccl_pkg::OFS_TEND) begin
      sp_reg[5'((i_paddr - ccl_pkg::OFS_TBL) >> 2)] <= i_pwdata;
    end
  end

  // commit request, held until the sequencer takes it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      commit_reg <= 1'b0;
    end else if (wr && i_paddr == ccl_pkg::OFS_CTRL && i_pwdata[ccl_pkg::CTRL_COMMIT]) begin
      commit_reg <= 1'b1;
    end else if (state_reg == ST_IDLE) begin
      commit_reg <= 1'b0;
    end
  end

  // sequencer: table check, segment search, division
  always_ff @(posedge i_clk) begin
    div_start_reg <= 1'b0;
    res_valid_reg <= 1'b0;
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      idx_reg <= '0;
      acnt_reg <= '0;
      reject_reg <= 1'b0;
      up_ok_reg <= 1'b0;
      dn_ok_reg <= 1'b0;
      xin_reg <= '0;
      pv_hold_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          idx_reg <= '0;
          up_ok_reg <= 1'b1;
          dn_ok_reg <= 1'b1;
          if (commit_reg) begin
            state_reg <= ST_CHECK;
          end else if (i_sample_valid) begin
            xin_reg <= (i_sample_pct > ccl_pkg::PCT_FULL) ? ccl_pkg::PCT_FULL : i_sample_pct;
            if (curve_en_reg && i_sample_class == cfg_reg.sens_class) begin
              state_reg <= ST_SEARCH;
            end else begin
              pv_hold_reg <= i_sample_pct;
              res_valid_reg <= 1'b1;
            end
          end
        end
        ST_SEARCH: begin
          if (xin_reg <= seg_b.x) begin
            div_start_reg <= 1'b1;
            state_reg <= ST_DIV;
          end else begin
            idx_reg <= idx_reg + 6'h01;
          end
        end
        ST_DIV: begin
          if (div_done) begin
            pv_hold_reg <= div_y;
            res_valid_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_CHECK: begin
          if (scnt_reg > ccl_pkg::INNER_LIM) begin
            reject_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (chk_b.x <= chk_a.x || (chk_b.y < chk_a.y && !dn_ok_reg)
                       || (chk_b.y > chk_a.y && !up_ok_reg)) begin
            reject_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            up_ok_reg <= up_ok_reg & (chk_b.y >= chk_a.y);
            dn_ok_reg <= dn_ok_reg & (chk_b.y <= chk_a.y);
            idx_reg <= idx_reg + 6'h01;
            if (idx_reg == scnt_reg) begin
              if ((up_ok_reg & (chk_b.y >= chk_a.y)) | (dn_ok_reg & (chk_b.y <= chk_a.y))) begin
                for (int i = 0; i < ccl_pkg::MAX_INNER; i++) begin
                  ap_reg[i] <= sp_reg[i];
                end
                acnt_reg <= scnt_reg;
                reject_reg <= 1'b0;
              end else begin
                reject_reg <= 1'b1;
              end
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  ccl_interp u_interp (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (div_start_reg),
    .i_x       (xin_reg),
    .i_a       (seg_a),
    .i_b       (seg_b),
    .o_done    (div_done),
    .o_y       (div_y)
  );

  // pv min/max pointers; a result landing with a clear is kept as the first point
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pv_min_reg <= '0;
      pv_max_reg <= '0;
      pv_seen_reg <= 1'b0;
    end else if (res_valid_reg) begin
      pv_seen_reg <= 1'b1;
      pv_min_reg <= (pv_fresh || pv_hold_reg < pv_min_reg) ? pv_hold_reg : pv_min_reg;
      pv_max_reg <= (pv_fresh || pv_hold_reg > pv_max_reg) ? pv_hold_reg : pv_max_reg;
    end else if (freset || pv_clr) begin
      pv_min_reg <= '0;
      pv_max_reg <= '0;
      pv_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || freset) begin
      pvrt_reg <= '0;
    end else if (i_hour_tick) begin
      pvrt_reg <= pvrt_reg + 32'h1;
    end
  end

  // device meters survive a factory reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dvrt_reg <= '0;
      et_min_reg <= ccl_pkg::MIN_RST;
      et_max_reg <= '0;
    end else begin
      if (i_hour_tick) begin
        dvrt_reg <= dvrt_reg + 32'h1;
      end
      if (i_etemp < et_min_reg) begin
        et_min_reg <= i_etemp;
      end
      if (i_etemp > et_max_reg) begin
        et_max_reg <= i_etemp;
      end
    end
  end

  // pick the enabled error with the best priority, lowest index on ties
  always_comb begin
    logic [1:0] best;
    best = 2'h3;
    diag_next = 3'h0;
    for (int f = 0; f < ccl_pkg::NUM_FN; f++) begin
      if (i_err_cond[f] && dcfg_reg[ccl_pkg::DCFG_IRQ_LSB + f]
          && (!diag_next[2] || dcfg_reg[ccl_pkg::DCFG_PRIO_LSB + 2 * f +: 2] < best)) begin
        best = dcfg_reg[ccl_pkg::DCFG_PRIO_LSB + 2 * f +: 2];
        diag_next = {1'b1, 2'(f)};
      end
    end
  end

  // diagnostic outputs and output value
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_alarm <= 1'b0;
      o_warn <= 1'b0;
      o_diag_code <= '0;
      o_pv_pct <= '0;
      o_pv_valid <= 1'b0;
    end else begin
      o_alarm <= |(i_err_cond & dcfg_reg[ccl_pkg::DCFG_IRQ_LSB +: 4]);
      o_warn <= |(i_limit_hit & dcfg_reg[ccl_pkg::DCFG_WARN_LSB +: 4]);
      o_diag_code <= diag_next;
      o_pv_pct <= diag_next[2] ? alarm_reg[15:0] : pv_hold_reg;
      o_pv_valid <= res_valid_reg;
    end
  end
endmodule
`default_nettype wire

// [core/ccl_pkg.sv]
package ccl_pkg;
  // percent units are hundredths of a percent of the span
  localparam logic [15:0] PCT_FULL  = 16'h2710;
  localparam int          MAX_PAIRS = 30;
  localparam int          MAX_INNER = MAX_PAIRS - 2;
  localparam logic [5:0]  INNER_LIM = 6'h1C;
  localparam int          NUM_FN    = 4;
  localparam int          DIV_STEPS = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_CFG   = 8'h08;
  localparam logic [7:0] OFS_SPAN  = 8'h0C;
  localparam logic [7:0] OFS_OFFS  = 8'h10;
  localparam logic [7:0] OFS_TRIM  = 8'h14;
  localparam logic [7:0] OFS_IDENT = 8'h18;
  localparam logic [7:0] OFS_AOUT  = 8'h1C;
  localparam logic [7:0] OFS_ALARM = 8'h20;
  localparam logic [7:0] OFS_PVMM  = 8'h24;
  localparam logic [7:0] OFS_ETMM  = 8'h28;
  localparam logic [7:0] OFS_PVRT  = 8'h2C;
  localparam logic [7:0] OFS_DVRT  = 8'h30;
  localparam logic [7:0] OFS_TCNT  = 8'h34;
  localparam logic [7:0] OFS_DCFG  = 8'h38;
  localparam logic [7:0] OFS_DSTAT = 8'h3C;
  localparam logic [7:0] OFS_TBL   = 8'h80;
  localparam logic [7:0] OFS_TEND  = 8'hEC;

  // control bit positions
  localparam int CTRL_CURVE_EN = 0;
  localparam int CTRL_COMMIT   = 1;
  localparam int CTRL_FRESET   = 2;
  localparam int CTRL_PV_CLR   = 3;

  // diagnostic config field positions
  localparam int DCFG_WARN_LSB = 0;
  localparam int DCFG_IRQ_LSB  = 4;
  localparam int DCFG_PRIO_LSB = 8;

  localparam logic       CLASS_RES = 1'b0;
  localparam logic       CLASS_MV  = 1'b1;
  localparam logic [1:0] CONN_3W   = 2'h1;
  localparam logic [2:0] LIN_TEMP  = 3'h0;

  typedef struct packed {
    logic [7:0] damping;
    logic [7:0] short_lim;
    logic [7:0] factor;
    logic [2:0] lin_type;
    logic       short_mon;
    logic       break_mon;
    logic [1:0] conn;
    logic       sens_class;
  } ccl_cfg_s;

  typedef struct packed {
    logic [15:0] y;
    logic [15:0] x;
  } ccl_pt_s;

  // factory defaults
  localparam ccl_cfg_s CFG_RST = '{damping: 8'h00, short_lim: 8'h0A,
    factor: 8'h64, lin_type: LIN_TEMP, short_mon: 1'b1, break_mon: 1'b1,
    conn: CONN_3W, sens_class: CLASS_RES};
  localparam logic [31:0] SPAN_RST  = 32'h0064_0000;
  localparam logic [31:0] DCFG_RST  = 32'h0000_0000;
  localparam logic [15:0] MIN_RST   = 16'hFFFF;
endpackage

// [sim/ccl_front_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ccl_front_model (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [15:0] i_pct,
  input  wire logic        i_class,
  output logic             o_sample_valid = 1'b0,
  output logic [15:0]      o_sample_pct = 16'h0000,
  output logic             o_sample_class = 1'b0
);
  // one normalized sample per request; lines toggle once released
  always @(posedge i_clk) begin
    o_sample_valid <= i_go;
    if (i_go) begin
      o_sample_pct   <= i_pct;
      o_sample_class <= i_class;
    end else begin
      o_sample_pct   <= ~o_sample_pct;
      o_sample_class <= ~o_sample_class;
    end
  end
endmodule
`default_nettype wire

// [sim/ccl_linearizer_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module ccl_linearizer_checker (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_sample_valid,
  input wire logic [3:0]  i_limit_hit,
  input wire logic [3:0]  i_err_cond,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_pv_valid,
  input wire logic [15:0] o_pv_pct,
  input wire logic        o_alarm,
  input wire logic        o_warn,
  input wire logic [2:0]  o_diag_code
);
  logic [7:0] since_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // cycles since the last sample, saturating; ff means no sample yet or 255 cycles or more since one
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      since_reg <= 8'hFF;
    end else if (i_sample_valid) begin
      since_reg <= 8'h00;
    end else if (since_reg != 8'hFF) begin
      since_reg <= since_reg + 8'h01;
    end
  end

  // bus answer timing and shape
  ready_access_a: assert property ($rose(i_penable) && i_psel |=> o_pready)
    else $error("pready missing after access start");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  slverr_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  // results and diagnostics tied to their causes
  pv_cause_a: assert property (o_pv_valid |-> since_reg <= 8'h64)
    else $error("result without recent sample");
  pv_range_a: assert property (o_pv_valid && !o_alarm |-> o_pv_pct <= 16'h2710)
    else $error("result above full span");
  alarm_cause_a: assert property (o_alarm |-> $past(|i_err_cond))
    else $error("alarm without error condition");
  warn_cause_a: assert property (o_warn |-> $past(|i_limit_hit))
    else $error("warning without limit crossing");
  alarm_code_a: assert property (o_alarm |-> o_diag_code[2])
    else $error("alarm without error code");
  pv_hold_a: assert property (!o_pv_valid && !o_alarm && !$past(o_alarm)
    |-> $stable(o_pv_pct))
    else $error("output moved without result or alarm");

  cover property (o_pv_valid);
  cover property (o_warn && !o_alarm);
  cover property (o_alarm && o_diag_code[2]);
endmodule

bind ccl_linearizer ccl_linearizer_checker i_chk (.i_clk, .i_sys_rst, .i_psel,
  .i_penable, .i_sample_valid, .i_limit_hit, .i_err_cond, .o_pready, .o_pslverr,
  .o_pv_valid, .o_pv_pct, .o_alarm, .o_warn, .o_diag_code);
`default_nettype wire

// [sim/ccl_linearizer_test.sv]
`timescale 1ns/10ps
`default_nettype none
module ccl_linearizer_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic        go = 1'b0;
  logic        gcls = 1'b0;
  logic        hour = 1'b0;
  logic [15:0] gpct = 16'h0;
  logic [3:0]  lim = 4'h0;
  logic [3:0]  err = 4'h0;
  logic [31:0] prd, rdat;
  logic [15:0] spct, pv;
  logic [2:0]  code;
  logic        rdy, serr, rerr, sv, scls, pvv, alm, wrn;
  int          failures = 0;
  int          samples_checked = 0;
  logic [15:0] etmp = 16'h0050;
  logic [31:0] tbl [4] = '{32'h05DC_03E8, 32'h07D0_07D0, 32'h157C_1388, 32'h251C_2328};
  logic [15:0] xs [5] = '{16'h0000, 16'h01F4, 16'h0DAC, 16'h251C, 16'h2710};
  logic [15:0] ys [5] = '{16'h0000, 16'h02EE, 16'h0EA6, 16'h2616, 16'h2710};

  ccl_front_model i_front (.i_clk(clk), .i_go(go), .i_pct(gpct), .i_class(gcls),
    .o_sample_valid(sv), .o_sample_pct(spct), .o_sample_class(scls));
  ccl_linearizer i_dut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(serr), .i_sample_valid(sv), .i_sample_pct(spct), .i_sample_class(scls),
    .i_hour_tick(hour), .i_etemp(etmp), .i_limit_hit(lim), .i_err_cond(err),
    .o_pv_valid(pvv), .o_pv_pct(pv), .o_alarm(alm), .o_warn(wrn), .o_diag_code(code));

  // free-running system clock
  initial begin
    forever #5 clk = ~clk;
  end

  task final_report();
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task timeout();
    failures++;
    final_report();
  endtask

  // one bus transfer: setup, then access held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) timeout();
    rdat = prd;
    rerr = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // poll status until commit and sequencer are done
  task idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while ((rdat[0] !== 1'b0 || rdat[2] !== 1'b0) && n < 50);
    if (rdat[0] !== 1'b0 || rdat[2] !== 1'b0) timeout();
  endtask

  // send one sample and compare the next result
  task sample(input logic [15:0] x, input logic c, input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    gpct <= x;
    gcls <= c;
    @(posedge clk);
    go <= 1'b0;
    while (pvv !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (pvv !== 1'b1) timeout();
    chk(32'(pv), 32'(exp));
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(8'h08, ccl_pkg::CFG_RST);
    rd(8'h0C, 32'h0064_0000);
    rd(8'h40, 32'h0);
    chk(32'(rerr), 32'h1);
    sample(16'h0DAC, 1'b0, 16'h0DAC);
    for (int i = 0; i < 4; i++) wr(8'h80 + 8'(4 * i), tbl[i]);
    wr(8'h34, 32'h4);
    wr(8'h00, 32'h2);
    idle();
    chk(32'(rdat[1]), 32'h0);
    wr(8'h00, 32'h1);
    for (int i = 0; i < 5; i++) sample(xs[i], 1'b0, ys[i]);
    sample(16'h0DAC, 1'b1, 16'h0DAC);
    wr(8'h08, 32'h000A_641B);
    sample(16'h0DAC, 1'b1, 16'h0EA6);
    sample(16'h0DAC, 1'b0, 16'h0DAC);
    wr(8'h34, 32'h1D);
    wr(8'h00, 32'h3);
    idle();
    chk(32'(rdat[1]), 32'h1);
    wr(8'h34, 32'h4);
    wr(8'h84, 32'h0100_07D0);
    wr(8'h00, 32'h3);
    idle();
    chk(32'(rdat[1]), 32'h1);
    sample(16'h0DAC, 1'b1, 16'h0EA6);
    wr(8'h38, 32'h0000_0131);
    wr(8'h20, 32'h0000_1234);
    lim <= 4'h1;
    repeat (3) @(posedge clk);
    chk(32'(wrn), 32'h1);
    chk(32'(pv), 32'h0EA6);
    err <= 4'h3;
    repeat (3) @(posedge clk);
    chk(32'(alm), 32'h1);
    chk(32'(pv), 32'h1234);
    chk(32'(code), 32'h5);
    err <= 4'h0;
    lim <= 4'h0;
    repeat (3) @(posedge clk);
    chk(32'(pv), 32'h0EA6);
    repeat (2) begin
      hour <= 1'b1;
      @(posedge clk);
      hour <= 1'b0;
      @(posedge clk);
    end
    etmp <= 16'h0300;
    @(posedge clk);
    etmp <= 16'h0123;
    rd(8'h24, 32'h2710_0000);
    wr(8'h10, 32'h5);
    wr(8'h14, 32'hAB);
    wr(8'h18, 32'h77);
    wr(8'h1C, 32'h99);
    wr(8'h00, 32'h4);
    idle();
    rd(8'h08, ccl_pkg::CFG_RST);
    rd(8'h0C, 32'h0064_0000);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h77);
    rd(8'h1C, 32'h99);
    rd(8'h20, 32'h1234);
    rd(8'h24, 32'h0);
    rd(8'h2C, 32'h0);
    rd(8'h30, 32'h2);
    rd(8'h28, 32'h0300_0050);
    sample(16'h0DAC, 1'b0, 16'h0DAC);
    rd(8'h24, 32'h0DAC_0DAC);
    wr(8'h00, 32'h8);
    rd(8'h24, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
